// *** pkg/psmc_regs.svh ***
// register offsets, field positions, reset values and delay counts
`ifndef PSMC_REGS_SVH
`define PSMC_REGS_SVH

`define PSMC_MCS_OFFS   12'h000
`define PSMC_STAT_OFFS  12'h004

`define PSMC_SME_BIT    0
`define PSMC_DIV_LSB    1
`define PSMC_DIV_MSB    2
`define PSMC_OIE_BIT    3
`define PSMC_DLY_BIT    4
`define PSMC_MCS_W      5
`define PSMC_MCS_RST    5'h00

`define PSMC_MODE_LSB   0
`define PSMC_BUSY_BIT   3
`define PSMC_BG_BIT     4

`define PSMC_DLY_SHORT  13'h0100
`define PSMC_DLY_LONG   13'h1000
`define PSMC_MASK_OPEN  2'h2

`endif

// *** pkg/psmc_pkg.sv ***
// types of the power saving mode controller
package psmc_pkg;

	typedef enum logic [2:0] {
		PSMC_ST_RUN   = 3'h0,
		PSMC_ST_WAIT  = 3'h1,
		PSMC_ST_AHALT = 3'h3,
		PSMC_ST_HALT  = 3'h2,
		PSMC_ST_STAB  = 3'h6
	} psmc_state_type;

	typedef enum logic [2:0] {
		PSMC_MODE_RUN   = 3'h0,
		PSMC_MODE_SLOW  = 3'h1,
		PSMC_MODE_WAIT  = 3'h2,
		PSMC_MODE_SWAIT = 3'h3,
		PSMC_MODE_AHALT = 3'h4,
		PSMC_MODE_HALT  = 3'h5
	} psmc_mode_type;

	typedef struct packed {
		psmc_state_type st;
		psmc_mode_type  mode;
		logic [4:0]     mcs;
		logic [31:0]    rdata;
		logic           boot;
		logic           bg;
		logic           wake;
		logic           push;
		logic           mask_we;
		logic [1:0]     mask;
		logic [1:0]     prio;
	} psmc_ctrl_type;

	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
		logic       sme;
		logic [1:0] sel;
	} psmc_div_type;

	typedef struct packed {
		logic [12:0] cnt;
	} psmc_stab_type;

endpackage

// *** logic/psmc_clk_div.sv ***
// slow mode divider of the master clock into a cpu clock enable
`timescale 1ns/1ps
`include "psmc_regs.svh"

module psmc_clk_div (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sme_i,
	input  wire logic [1:0] sel_i,
	output logic            tick_o
);

	psmc_pkg::psmc_div_type s_r;
	psmc_pkg::psmc_div_type s_nxt;

	// last count of a 2, 4, 8 or 16 division
	function automatic logic [3:0] div_last(input logic [1:0] sel);
		div_last = 4'((5'h02 << sel) - 5'h01);
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!s_r.sme || s_r.cnt >= div_last(s_r.sel)) begin
			s_nxt.tick = 1'b1;
			s_nxt.cnt = 4'h0;
			// settings only taken at a tick, so a period is never cut
			s_nxt.sme = sme_i;
			s_nxt.sel = sel_i;
		end else begin
			s_nxt.cnt = s_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;

endmodule

// *** logic/psmc_stab_cnt.sv ***
// oscillator stabilisation delay counter
`timescale 1ns/1ps
`include "psmc_regs.svh"

module psmc_stab_cnt (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	input  wire logic long_i,
	output logic      busy_o,
	output logic      done_o
);

	psmc_pkg::psmc_stab_type s_r;
	psmc_pkg::psmc_stab_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (start_i) begin
			s_nxt.cnt = long_i ? `PSMC_DLY_LONG : `PSMC_DLY_SHORT;
		end else if (s_r.cnt != 13'h0000) begin
			s_nxt.cnt = s_r.cnt - 13'h0001;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o = (s_r.cnt != 13'h0000);
	assign done_o = (s_r.cnt == 13'h0001);

endmodule

// *** logic/psmc_ctrl.sv ***
// power saving mode controller: run, slow, wait, active-halt and halt
// Operation
// - after reset run mode, cpu and peripherals on the master clock
// - slow mode set by an enable bit and a two-bit divider select
// - slow mode divides the master clock by 2, 4, 8 or 16
// - wait entered during slow mode gives slow-wait on the divided clock
// - wait-for-interrupt instruction stops the cpu, enters wait
// - peripherals keep their clock during wait
// - entering wait forces the interrupt mask bits to 10
// - wait ends on interrupt or reset, cpu goes to the routine
// - servicing pushes the condition code, then loads the routine priority
// - halt instruction gives halt if oscillator irq enable 0, else active-halt
// - active-halt ends on time base interrupt, chosen interrupts or reset
// - no stabilisation delay when active-halt ends by interrupt
// - entering active-halt forces mask bits to 10, pending irq wakes
// - active-halt runs only the oscillator and time base counter
// - active-halt holds the watchdog so it causes no reset
// - after active-halt the cpu services the interrupt or the reset vector
// - halt switches the oscillator off, stopping cpu and peripherals
// - leaving halt restarts the oscillator and waits the stabilisation delay
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "psmc_regs.svh"

module psmc_ctrl (
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        wfi_exec_i,
	input  wire logic        halt_exec_i,
	input  wire logic        irq_pending_i,
	input  wire logic        irq_wake_halt_i,
	input  wire logic        irq_wake_ahalt_i,
	input  wire logic        tbase_irq_i,
	input  wire logic        irq_take_i,
	input  wire logic [1:0]  irq_prio_i,
	output logic [2:0]       mode_o,
	output logic             cpu_clk_en_o,
	output logic             periph_clk_en_o,
	output logic             tbase_clk_en_o,
	output logic             osc_en_o,
	output logic             wdg_hold_o,
	output logic             wake_o,
	output logic             cc_push_o,
	output logic             cc_mask_we_o,
	output logic [1:0]       cc_mask_o
);

	logic                    rst_meta_r;
	logic                    rst_n;
	psmc_pkg::psmc_ctrl_type s_r;
	psmc_pkg::psmc_ctrl_type s_nxt;
	logic                    tick;
	logic                    stab_start;
	logic                    stab_busy;
	logic                    stab_done;
	logic                    sme;
	logic [1:0]              div_sel;
	logic                    oscillator_interrupt_enable;
	logic                    dly_long;
	logic                    acc;
	logic                    wr_mcs;
	logic                    in_run;

	// reset release through two flops
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// control bits of the main clock status register
	assign sme      = s_r.mcs[`PSMC_SME_BIT];
	assign div_sel  = s_r.mcs[`PSMC_DIV_MSB:`PSMC_DIV_LSB];
	assign oscillator_interrupt_enable      = s_r.mcs[`PSMC_OIE_BIT];
	assign dly_long = s_r.mcs[`PSMC_DLY_BIT];

	// cpu clock enable divided in slow mode
	psmc_clk_div psmc_clk_div_i (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n),
		.sme_i      (sme),
		.sel_i      (div_sel),
		.tick_o     (tick)
	);

	psmc_stab_cnt psmc_stab_cnt_i (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n),
		.start_i    (stab_start),
		.long_i     (dly_long),
		.busy_o     (stab_busy),
		.done_o     (stab_done)
	);

	assign acc    = psel_i && penable_i;
	assign wr_mcs = acc && pwrite_i && (paddr_i == `PSMC_MCS_OFFS);
	assign in_run = (s_r.st == psmc_pkg::PSMC_ST_RUN);

	// mode code seen by software on mode_o and in the status register
	function automatic psmc_pkg::psmc_mode_type mode_of(input psmc_pkg::psmc_state_type st,
			input logic slow);
		case (st)
			psmc_pkg::PSMC_ST_RUN:   mode_of = slow ? psmc_pkg::PSMC_MODE_SLOW
				: psmc_pkg::PSMC_MODE_RUN;
			psmc_pkg::PSMC_ST_WAIT:  mode_of = slow ? psmc_pkg::PSMC_MODE_SWAIT
				: psmc_pkg::PSMC_MODE_WAIT;
			psmc_pkg::PSMC_ST_AHALT: mode_of = psmc_pkg::PSMC_MODE_AHALT;
			default:                 mode_of = psmc_pkg::PSMC_MODE_HALT;
		endcase
	endfunction

	always_comb begin
		s_nxt = s_r;
		stab_start = 1'b0;
		s_nxt.wake = 1'b0;
		s_nxt.push = 1'b0;
		s_nxt.mask_we = 1'b0;
		// first cycle after reset starts the stabilisation delay
		if (s_r.boot) begin
			stab_start = 1'b1;
			s_nxt.boot = 1'b0;
		end
		if (wr_mcs) begin
			s_nxt.mcs = pwdata_i[`PSMC_MCS_W-1:0];
		end
		// push first, routine priority into the mask next cycle
		if (irq_take_i) begin
			s_nxt.push = 1'b1;
			s_nxt.prio = irq_prio_i;
		end
		if (s_r.push) begin
			s_nxt.mask_we = 1'b1;
			s_nxt.mask = s_r.prio;
		end
		// old count ending loses to a wake that restarts it aside
		if (stab_done) begin
			s_nxt.bg = 1'b0;
		end
		case (s_r.st)
			psmc_pkg::PSMC_ST_RUN: begin
				if (wfi_exec_i) begin
					s_nxt.st = psmc_pkg::PSMC_ST_WAIT;
					s_nxt.mask_we = 1'b1;
					s_nxt.mask = `PSMC_MASK_OPEN;
				end else if (halt_exec_i) begin
					// oscillator irq enable picks the halt flavour
					s_nxt.st = oscillator_interrupt_enable ? psmc_pkg::PSMC_ST_AHALT : psmc_pkg::PSMC_ST_HALT;
					// mask opened, a pending irq wakes at once
					s_nxt.mask_we = 1'b1;
					s_nxt.mask = `PSMC_MASK_OPEN;
				end else if (s_r.bg && stab_busy && !oscillator_interrupt_enable) begin
					// enable cleared before the delay ran out
					s_nxt.st = psmc_pkg::PSMC_ST_STAB;
				end
			end
			psmc_pkg::PSMC_ST_WAIT: begin
				// any interrupt resumes the cpu at its routine
				if (irq_pending_i) begin
					s_nxt.st = psmc_pkg::PSMC_ST_RUN;
					s_nxt.wake = 1'b1;
				end
			end
			psmc_pkg::PSMC_ST_AHALT: begin
				// time base or chosen interrupt ends active-halt
				if (tbase_irq_i || irq_wake_ahalt_i) begin
					// cpu resumes at once, delay only counted aside
					s_nxt.st = psmc_pkg::PSMC_ST_RUN;
					s_nxt.wake = 1'b1;
					s_nxt.bg = 1'b1;
					stab_start = 1'b1;
				end
			end
			psmc_pkg::PSMC_ST_HALT: begin
				// oscillator restarts, delay before the cpu runs
				if (irq_wake_halt_i) begin
					s_nxt.st = psmc_pkg::PSMC_ST_STAB;
					stab_start = 1'b1;
				end
			end
			psmc_pkg::PSMC_ST_STAB: begin
				if (stab_done) begin
					s_nxt.st = psmc_pkg::PSMC_ST_RUN;
					s_nxt.wake = !s_r.bg;
				end
			end
			default: begin
				s_nxt.st = psmc_pkg::PSMC_ST_RUN;
			end
		endcase
		s_nxt.mode = mode_of(s_nxt.st, s_nxt.mcs[`PSMC_SME_BIT]);
		// read data caught in the setup cycle
		if (psel_i && !penable_i) begin
			s_nxt.rdata = 32'h0000_0000;
			if (paddr_i == `PSMC_MCS_OFFS) begin
				s_nxt.rdata[`PSMC_MCS_W-1:0] = s_r.mcs;
			end else if (paddr_i == `PSMC_STAT_OFFS) begin
				s_nxt.rdata[`PSMC_MODE_LSB+2:`PSMC_MODE_LSB] = s_r.mode;
				s_nxt.rdata[`PSMC_BUSY_BIT] = stab_busy;
				s_nxt.rdata[`PSMC_BG_BIT] = s_r.bg;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: psmc_pkg::PSMC_ST_RUN, mode: psmc_pkg::PSMC_MODE_RUN,
				mcs: `PSMC_MCS_RST, rdata: 32'h0000_0000, boot: 1'b1, bg: 1'b0,
				wake: 1'b0, push: 1'b0, mask_we: 1'b0, mask: 2'h0, prio: 2'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready_o  = acc;
	assign pslverr_o = acc && (paddr_i != `PSMC_MCS_OFFS) && (paddr_i != `PSMC_STAT_OFFS);
	assign prdata_o  = s_r.rdata;

	// cpu clock held while the boot delay runs
	assign cpu_clk_en_o = in_run && tick && !(stab_busy && !s_r.bg);
	// wait and slow-wait keep the (divided) peripheral clock
	assign periph_clk_en_o = (in_run || s_r.st == psmc_pkg::PSMC_ST_WAIT) && tick;
	// only the time base keeps running in active-halt
	assign tbase_clk_en_o = (in_run || s_r.st == psmc_pkg::PSMC_ST_WAIT
		|| s_r.st == psmc_pkg::PSMC_ST_AHALT) && tick;
	assign osc_en_o = (s_r.st != psmc_pkg::PSMC_ST_HALT);
	assign wdg_hold_o   = (s_r.st == psmc_pkg::PSMC_ST_AHALT);
	assign wake_o       = s_r.wake;
	assign cc_push_o    = s_r.push;
	assign cc_mask_we_o = s_r.mask_we;
	assign cc_mask_o    = s_r.mask;
	assign mode_o       = s_r.mode;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence halt_wake_s;
		s_r.st == psmc_pkg::PSMC_ST_HALT && irq_wake_halt_i && !dly_long;
	endsequence

	sequence stab_hold_s;
		(s_r.st == psmc_pkg::PSMC_ST_STAB && !cpu_clk_en_o) [*8];
	endsequence

	sequence take_s;
		irq_take_i && !s_r.push;
	endsequence

	a_wait_entry: assert property (in_run && wfi_exec_i |=>
		s_r.st == psmc_pkg::PSMC_ST_WAIT && cc_mask_we_o && cc_mask_o == 2'h2)
		else $error("wait entry did not open the mask");

	a_wait_mode: assert property (s_r.st == psmc_pkg::PSMC_ST_WAIT && !irq_pending_i
		&& !wr_mcs |=> mode_o == (sme ? 3'h3 : 3'h2))
		else $error("wait mode code wrong");

	a_wait_wake: assert property (s_r.st == psmc_pkg::PSMC_ST_WAIT && irq_pending_i
		|=> in_run && wake_o)
		else $error("wait did not end on interrupt");

	a_halt_select: assert property (in_run && halt_exec_i && !wfi_exec_i
		|=> s_r.st == ($past(oscillator_interrupt_enable) ? psmc_pkg::PSMC_ST_AHALT : psmc_pkg::PSMC_ST_HALT))
		else $error("halt flavour wrong");

	a_ahalt_exit: assert property (s_r.st == psmc_pkg::PSMC_ST_AHALT && tbase_irq_i
		|=> in_run && wake_o && s_r.bg && stab_busy)
		else $error("active-halt exit was delayed");

	a_ahalt_clocks: assert property (s_r.st == psmc_pkg::PSMC_ST_AHALT |->
		osc_en_o && wdg_hold_o && !periph_clk_en_o && !cpu_clk_en_o)
		else $error("clock gating in active-halt wrong");

	a_halt_osc: assert property (s_r.st == psmc_pkg::PSMC_ST_HALT |->
		!osc_en_o && !cpu_clk_en_o && !tbase_clk_en_o)
		else $error("oscillator running in halt");

	a_halt_delay: assert property (halt_wake_s |=> stab_hold_s ##1 1'b1
		##240 s_r.st == psmc_pkg::PSMC_ST_STAB ##8 in_run && wake_o)
		else $error("halt exit delay is not 256 cycles");

	a_irq_push: assert property (take_s |=> cc_push_o ##1
		(cc_mask_we_o && cc_mask_o == $past(irq_prio_i, 2)))
		else $error("push and priority load out of order");

	a_early_clear: assert property (in_run && s_r.bg && stab_busy && !oscillator_interrupt_enable
		&& !wfi_exec_i && !halt_exec_i |=> s_r.st == psmc_pkg::PSMC_ST_STAB)
		else $error("early enable clear did not halt");

	a_slow_div: assert property (cpu_clk_en_o && sme && div_sel == 2'h3
		&& !wr_mcs && !$past(wr_mcs) |=> !cpu_clk_en_o [*8])
		else $error("divide by 16 ticks too often");

endmodule

// *** tb/psmc_cpu_model.sv ***
// cpu core and interrupt source model
`timescale 1ns/1ps

module psmc_cpu_model (
	input  wire logic  core_clk_i,
	output logic       wfi_exec_o,
	output logic       halt_exec_o,
	output logic [3:0] irq_o,
	output logic       irq_take_o,
	output logic [1:0] irq_prio_o
);
	initial begin
		wfi_exec_o = 1'b0;
		halt_exec_o = 1'b0;
		irq_o = 4'h0;
		irq_take_o = 1'b0;
		irq_prio_o = 2'h0;
	end

	// one-cycle wait or halt instruction
	task automatic exec(input logic h);
		@(posedge core_clk_i);
		wfi_exec_o <= ~h;
		halt_exec_o <= h;
		@(posedge core_clk_i);
		wfi_exec_o <= 1'b0;
		halt_exec_o <= 1'b0;
	endtask

	// lines: 0 pending, 1 halt wake, 2 active-halt wake, 3 time base
	task automatic raise(input int w);
		@(posedge core_clk_i);
		irq_o[w] <= 1'b1;
	endtask

	task automatic clear();
		@(posedge core_clk_i);
		irq_o <= 4'h0;
	endtask

	// start of service, pop is left to the cpu
	task automatic take(input logic [1:0] p);
		@(posedge core_clk_i);
		irq_take_o <= 1'b1;
		irq_prio_o <= p;
		@(posedge core_clk_i);
		irq_take_o <= 1'b0;
	endtask
endmodule

// *** tb/power_saving_mode_control_tb.sv ***
// self-checking bench of the power saving mode controller
`timescale 1ns/1ps

module power_saving_mode_control_tb;
	logic        core_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        wait_for_interrupt_instruction, hlt, take, cpu_en, per_en, tb_en, osc_en, wdg, wake, push, mwe;
	logic [3:0]  irq;
	logic [1:0]  prio, mask;
	logic [2:0]  mode;
	int          n_errors, checks_done, n_wake, n, nc, np, nt, no, nw;

	psmc_ctrl psmc_ctrl_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .wfi_exec_i(wait_for_interrupt_instruction),
		.halt_exec_i(hlt), .irq_pending_i(irq[0]), .irq_wake_halt_i(irq[1]),
		.irq_wake_ahalt_i(irq[2]), .tbase_irq_i(irq[3]), .irq_take_i(take),
		.irq_prio_i(prio), .mode_o(mode), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
		.tbase_clk_en_o(tb_en), .osc_en_o(osc_en), .wdg_hold_o(wdg), .wake_o(wake),
		.cc_push_o(push), .cc_mask_we_o(mwe), .cc_mask_o(mask));

	psmc_cpu_model psmc_cpu_model_i (.core_clk_i(core_clk_i), .wfi_exec_o(wait_for_interrupt_instruction),
		.halt_exec_o(hlt), .irq_o(irq), .irq_take_o(take), .irq_prio_o(prio));

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) if (wake === 1'b1) n_wake++;

	task automatic final_report();
		if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge core_clk_i);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// counts cycles until wake (sel 0) or a cpu clock enable (sel 1)
	task automatic until_hi(input int sel, output int c);
		for (c = 1; c <= 5000; c++) begin
			@(negedge core_clk_i);
			if ((sel == 0 ? wake : cpu_en) === 1'b1) return;
		end
		n_errors++;
		final_report();
	endtask

	task automatic watch(input int cyc);
		nc = 0;
		np = 0;
		nt = 0;
		no = 0;
		repeat (cyc) begin
			@(negedge core_clk_i);
			nc += int'(cpu_en === 1'b1);
			np += int'(per_en === 1'b1);
			nt += int'(tb_en === 1'b1);
			no += int'(osc_en === 1'b1);
		end
	endtask

	task automatic enter(input logic h, input logic [2:0] m);
		psmc_cpu_model_i.exec(h);
		@(negedge core_clk_i);
		check("entry mode", mode, m);
		check("mask write", mwe, 1'b1);
		check("mask value", mask, 2'h2);
	endtask

	task automatic wake_by(input int w);
		psmc_cpu_model_i.raise(w);
		until_hi(0, n);
		psmc_cpu_model_i.clear();
		@(negedge core_clk_i);
	endtask

	initial begin
		nrst_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		until_hi(1, n);
		check("boot delay", n >= 256 && n <= 262, 1'b1);
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b1, 12'h004, 32'h1f);
		apb(1'b0, 12'h000, 32'h0);
		check("read-only status", rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		check("reset mode", rd[2:0], psmc_pkg::PSMC_MODE_RUN);
		apb(1'b1, 12'h008, 32'h1);
		check("unmapped error", err, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		check("unmapped read", rd, 32'h0);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, 12'h000, {29'h0, s[1:0], 1'b1});
			repeat (40) @(posedge core_clk_i);
			until_hi(1, n);
			until_hi(1, n);
			check("slow divide", n, 2 << s);
			check("slow mode", mode, psmc_pkg::PSMC_MODE_SLOW);
		end
		enter(1'b0, psmc_pkg::PSMC_MODE_SWAIT);
		watch(64);
		check("slow-wait cpu", nc, 0);
		check("slow-wait periph", np != 0, 1'b1);
		wake_by(0);
		check("slow-wait wake", n <= 2, 1'b1);
		check("back to slow", mode, psmc_pkg::PSMC_MODE_SLOW);
		apb(1'b1, 12'h000, 32'h0);
		repeat (40) @(posedge core_clk_i);
		enter(1'b0, psmc_pkg::PSMC_MODE_WAIT);
		watch(20);
		check("wait periph", np, 20);
		wake_by(0);
		check("wait wake", n <= 2, 1'b1);
		psmc_cpu_model_i.take(2'h1);
		@(negedge core_clk_i);
		check("cc push", push, 1'b1);
		@(negedge core_clk_i);
		check("prio load", {mwe, mask}, 3'h5);
		enter(1'b1, psmc_pkg::PSMC_MODE_HALT);
		watch(50);
		check("halt clocks", no + nc + np + nt, 0);
		wake_by(1);
		check("halt exit delay", n >= 256 && n <= 260, 1'b1);
		check("halt exit mode", mode, psmc_pkg::PSMC_MODE_RUN);
		apb(1'b1, 12'h000, 32'h8);
		enter(1'b1, psmc_pkg::PSMC_MODE_AHALT);
		watch(50);
		check("active-halt cpu periph", nc + np, 0);
		check("active-halt time base", nt != 0 && no == 50, 1'b1);
		check("watchdog hold", wdg, 1'b1);
		wake_by(3);
		check("time base wake", n <= 2, 1'b1);
		check("resume mode", mode, psmc_pkg::PSMC_MODE_RUN);
		repeat (300) @(posedge core_clk_i);
		enter(1'b1, psmc_pkg::PSMC_MODE_AHALT);
		wake_by(2);
		check("designated wake", n <= 2, 1'b1);
		nw = n_wake;
		// early clear of the oscillator enable
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		check("early clear mode", rd[2:0], psmc_pkg::PSMC_MODE_HALT);
		repeat (300) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check("no extra wake", n_wake, nw);
		check("after delay", mode, psmc_pkg::PSMC_MODE_RUN);
		// long stabilisation delay selected
		apb(1'b1, 12'h000, 32'h10);
		enter(1'b1, psmc_pkg::PSMC_MODE_HALT);
		wake_by(1);
		check("long halt delay", n >= 4096 && n <= 4100, 1'b1);
		check("long halt mode", mode, psmc_pkg::PSMC_MODE_RUN);
		final_report();
	end
endmodule
